// file: common/psg_pkg.sv
package psg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int PSG_CH        = 4;
  localparam int PSG_WORD_W    = 256;
  localparam int PSG_MEM_WORDS = 16;
  localparam int PSG_SLICE_W   = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] PSG_OFS_CTRL     = 8'h00;
  localparam logic [7:0] PSG_OFS_OUT_EN   = 8'h04;
  localparam logic [7:0] PSG_OFS_RESTART  = 8'h08;
  localparam logic [7:0] PSG_OFS_ERR_IVL  = 8'h0c;
  localparam logic [7:0] PSG_OFS_MEM_ADDR = 8'h10;
  localparam logic [7:0] PSG_OFS_MEM_DATA = 8'h14;
  localparam logic [7:0] PSG_OFS_PAIR_LEN = 8'h18;
  localparam logic [7:0] PSG_OFS_STATUS   = 8'h1c;
  localparam logic [3:0] PSG_PAGE_CH_CFG  = 4'h2;
  localparam logic [3:0] PSG_PAGE_CH_DLY  = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PSG_CTRL_FULL    = 0;
  localparam int PSG_CTRL_SEL_LSB = 2;
  localparam int PSG_MA_CH_LSB    = 0;
  localparam int PSG_MA_SLICE_LSB = 4;
  localparam int PSG_MA_WORD_LSB  = 8;
  localparam int PSG_PL_B_LSB     = 4;
  localparam int PSG_CFG_PAT_LSB  = 0;
  localparam int PSG_CFG_INV      = 4;
  localparam int PSG_CFG_HALVE    = 5;
  localparam int PSG_CFG_ERR      = 6;
  localparam int PSG_CFG_GRP_LSB  = 8;
  localparam int PSG_ST_HOLD      = 4;
  localparam int PSG_ST_OE_LSB    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [15:0] PSG_ERR_IVL_RST = 16'h03e8;
  localparam logic [2:0]  PSG_SEL_RST     = 3'h0;
  localparam logic [2:0]  PSG_SEL_MAX     = 3'h6;
  localparam logic [3:0]  PSG_OE_RST      = 4'h0;
  localparam logic [30:0] PSG_PRBS_SEED   = 31'h7fffffff;
  localparam logic [3:0]  PSG_PAT_USER    = 4'h9;

  // Feedback tap masks, one per sequence length
  function automatic logic [30:0] psg_taps(input logic [3:0] code);
    logic [30:0] m;
    m = 31'h48000000;
    unique case (code)
      4'h0: m = 31'h00000060;
      4'h1: m = 31'h00000110;
      4'h2: m = 31'h00000240;
      4'h3: m = 31'h00000500;
      4'h4: m = 31'h00001803;
      4'h5: m = 31'h00006000;
      4'h6: m = 31'h00080004;
      4'h7: m = 31'h00420000;
      default: m = 31'h48000000;
    endcase
    return m;
  endfunction : psg_taps

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [1:0] group;
    logic       err_en;
    logic       halve;
    logic       invert;
    logic [3:0] pattern;
  } psg_ch_cfg_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  ch;
    logic [3:0]  word;
    logic [2:0]  slice;
    logic [31:0] data;
  } psg_mem_wr_t;

endpackage : psg_pkg

// file: verilog/psg_store.sv
`timescale 1ns/1ps
module psg_store
  import psg_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  ce,
  input  wire logic                  wr_en,
  input  wire logic [3:0]            wr_word,
  input  wire logic [2:0]            wr_slice,
  input  wire logic [31:0]           wr_data,
  input  wire logic [3:0]            rd_word,
  output logic      [PSG_WORD_W-1:0] rd_data
);

  // Pattern words, one slice written at a time
  logic [PSG_WORD_W-1:0] mem [PSG_MEM_WORDS];

  // Slice write
  always_ff @(posedge sys_clk) begin
    if (ce && wr_en) begin
      mem[wr_word][{wr_slice, 5'h00} +: PSG_SLICE_W] <= wr_data;
    end
  end

  // Whole-word read
  assign rd_data = mem[rd_word];

endmodule : psg_store

// file: verilog/psg_top.sv
// Overview of operation
// - All outputs step from the single sys_clk, so bit rate follows it.
// - Half clock mode emits two bits per input clock.
// - Full clock mode divides input clock by two for internal stepping.
// - Selectable clock output is input clock divided by 2 to 128.
// - Channels in one group restart together and stay bit-synchronous.
// - Sequences of length 2^k-1, k = 7,9,10,11,13,15,20,23,31.
// - Each channel selects a sequence or user pattern on its own.
// - Per-channel inversion complements every generated bit.
// - Sequence start point offset per channel in single-bit steps.
// - Bit-rate halving sends every pattern bit twice.
// - Error injection corrupts the stream at a fixed rate.
// - Channel outputs have own enables and are off from reset until enabled.
// - Each channel owns a dedicated user pattern store.
// - Pattern store is read in 256-bit words.
// - Channels 1,3 and 2,4 share one pattern length; each channel has its own read pointer.
// - Each output is a 2:1 mux of two half-rate bit lanes.
`timescale 1ns/1ps
module psg_top
  import psg_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wr_data,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [31:0]      rd_data,
  output logic      [3:0][1:0]  ch_data,
  output logic      [3:0]       ch_drive,
  output logic                  clk_half_out,
  output logic                  clk_sel_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Software state
  logic              full_mode;
  logic [2:0]        clk_sel;
  logic [3:0]        out_en;
  logic [15:0]       err_ivl;
  logic [11:0]       mem_addr;
  logic [3:0]        len_a;
  logic [3:0]        len_b;
  psg_ch_cfg_t       cfg   [PSG_CH];
  logic [30:0]       delay [PSG_CH];

  // Internal timing
  logic              half_phase;
  logic [6:0]        div_cnt;
  logic [6:0]        next_div;
  logic              step;
  logic              hold;
  logic [3:0]        skip_busy;
  logic [3:0]        restart;
  logic [3:0]        restart_grp;
  psg_mem_wr_t       mem_wr;

  // Decoded strobes
  logic              wr_ctrl;
  logic              wr_oe;
  logic              wr_rst;
  logic              wr_ivl;
  logic              wr_ma;
  logic              wr_md;
  logic              wr_pl;
  logic              wr_cfg;
  logic              wr_dly;
  logic [1:0]        sel_ch;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_ctrl = wr_en && (addr == PSG_OFS_CTRL);
  assign wr_oe   = wr_en && (addr == PSG_OFS_OUT_EN);
  assign wr_rst  = wr_en && (addr == PSG_OFS_RESTART);
  assign wr_ivl  = wr_en && (addr == PSG_OFS_ERR_IVL);
  assign wr_ma   = wr_en && (addr == PSG_OFS_MEM_ADDR);
  assign wr_md   = wr_en && (addr == PSG_OFS_MEM_DATA);
  assign wr_pl   = wr_en && (addr == PSG_OFS_PAIR_LEN);
  assign wr_cfg  = wr_en && (addr[7:4] == PSG_PAGE_CH_CFG);
  assign wr_dly  = wr_en && (addr[7:4] == PSG_PAGE_CH_DLY);
  assign sel_ch  = addr[3:2];

  ////////////////////////////////////////////////////////////////////////////
  // Global control registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      full_mode <= 1'b0;
      clk_sel   <= PSG_SEL_RST;
    end else if (ce && wr_ctrl) begin
      full_mode <= wr_data[PSG_CTRL_FULL];
      clk_sel   <= wr_data[PSG_CTRL_SEL_LSB +: 3];
    end
  end
  // Output enables, cleared by reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      out_en <= PSG_OE_RST;
    end else if (ce && wr_oe) begin
      out_en <= wr_data[3:0];
    end
  end

  // Error interval
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      err_ivl <= PSG_ERR_IVL_RST;
    end else if (ce && wr_ivl) begin
      err_ivl <= wr_data[15:0];
    end
  end

  // Pattern store pointer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mem_addr <= 12'h000;
    end else if (ce && wr_ma) begin
      mem_addr <= wr_data[11:0];
    end
  end

  // Shared length per channel pair
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      len_a <= 4'h0;
      len_b <= 4'h0;
    end else if (ce && wr_pl) begin
      len_a <= wr_data[3:0];
      len_b <= wr_data[PSG_PL_B_LSB +: 4];
    end
  end

  // Per-channel configuration
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < PSG_CH; i++) begin
        cfg[i]   <= '0;
        delay[i] <= 31'h00000000;
      end
    end else if (ce) begin
      if (wr_cfg) begin
        cfg[sel_ch].pattern <= wr_data[PSG_CFG_PAT_LSB +: 4];
        cfg[sel_ch].invert  <= wr_data[PSG_CFG_INV];
        cfg[sel_ch].halve   <= wr_data[PSG_CFG_HALVE];
        cfg[sel_ch].err_en  <= wr_data[PSG_CFG_ERR];
        cfg[sel_ch].group   <= wr_data[PSG_CFG_GRP_LSB +: 2];
      end
      if (wr_dly) begin
        delay[sel_ch] <= wr_data[30:0];
      end
    end
  end

  // Store write request from the data port
  assign mem_wr.en    = wr_md;
  assign mem_wr.ch    = mem_addr[PSG_MA_CH_LSB +: 2];
  assign mem_wr.slice = mem_addr[PSG_MA_SLICE_LSB +: 3];
  assign mem_wr.word  = mem_addr[PSG_MA_WORD_LSB +: 4];
  assign mem_wr.data  = wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Clock distribution
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      half_phase <= 1'b0;
    end else if (ce) begin
      half_phase <= ~half_phase;
    end
  end

  // Free-running divider chain
  assign next_div = 7'(div_cnt + 7'h01);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_cnt     <= 7'h00;
      clk_sel_out <= 1'b0;
    end else if (ce) begin
      div_cnt     <= next_div;
      // Bit k toggles every 2^k clocks: ratio 2^(k+1)
      clk_sel_out <= next_div[(clk_sel > PSG_SEL_MAX) ? PSG_SEL_MAX : clk_sel];
    end
  end

  assign clk_half_out = half_phase;
  // One common step for every channel; held while any offset is applied
  assign hold = |skip_busy;
  assign step = (full_mode ? half_phase : 1'b1) && !hold;

  // Group restart: channels whose group bit is set
  always_comb begin
    for (int i = 0; i < PSG_CH; i++) begin
      restart_grp[i] = wr_data[cfg[i].group];
      restart[i]     = wr_rst && restart_grp[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar c = 0; c < PSG_CH; c++) begin : g_ch
    logic [30:0]           lfsr;
    logic [30:0]           skip_cnt;
    logic                  skip;
    logic [3:0]            wptr;
    logic [7:0]            bptr;
    logic [15:0]           ecnt;
    logic [PSG_WORD_W-1:0] word;
    logic [30:0]           taps;
    logic                  fb0;
    logic                  fb1;
    logic [30:0]           s1;
    logic [30:0]           s2;
    logic                  is_user;
    logic [1:0]            raw;
    logic [1:0]            pol;
    logic                  hit;
    logic [8:0]            next_bptr;
    logic [3:0]            len;

    // Pair 1,3 uses length A and pair 2,4 length B
    assign len = (c % 2 == 0) ? len_a : len_b;
    psg_store u_store (
      .sys_clk  (sys_clk),
      .ce       (ce),
      .wr_en    (mem_wr.en && (mem_wr.ch == 2'(c))),
      .wr_word  (mem_wr.word),
      .wr_slice (mem_wr.slice),
      .wr_data  (mem_wr.data),
      .rd_word  (wptr),
      .rd_data  (word)
    );
    // Two sequence steps per clock
    assign taps = psg_taps(cfg[c].pattern);
    assign fb0  = ^(lfsr & taps);
    assign s1   = {lfsr[29:0], fb0};
    assign fb1  = ^(s1 & taps);
    assign s2   = {s1[29:0], fb1};
    // Source bits, first bit in position 1
    assign is_user = (cfg[c].pattern == PSG_PAT_USER);
    always_comb begin
      if (is_user) begin
        raw = cfg[c].halve ? {2{word[bptr]}} : {word[bptr], word[8'(bptr + 8'h01)]};
      end else begin
        raw = cfg[c].halve ? {fb0, fb0} : {fb0, fb1};
      end
    end

    assign pol = raw ^ {2{cfg[c].invert}};
    assign hit = cfg[c].err_en && (ecnt >= 16'(err_ivl - 16'h0001));
    // Word pointer advance, 1 or 2 bits a step
    assign next_bptr = {1'b0, bptr} + (cfg[c].halve ? 9'h001 : 9'h002);
    // Sequence state and start offset
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        lfsr     <= PSG_PRBS_SEED;
        skip     <= 1'b0;
        skip_cnt <= 31'h00000000;
      end else if (ce) begin
        if (restart[c]) begin
          lfsr     <= PSG_PRBS_SEED;
          skip     <= !is_user && (delay[c] != 31'h00000000);
          skip_cnt <= delay[c];
        end else if (skip) begin
          lfsr     <= s1;
          skip_cnt <= 31'(skip_cnt - 31'h00000001);
          skip     <= (skip_cnt != 31'h00000001);
        end else if (step) begin
          lfsr <= cfg[c].halve ? s1 : s2;
        end
      end
    end

    // User pattern read pointer
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        bptr <= 8'h00;
        wptr <= 4'h0;
      end else if (ce) begin
        if (restart[c]) begin
          bptr <= 8'h00;
          wptr <= 4'h0;
        end else if (step && is_user) begin
          bptr <= next_bptr[7:0];
          if (next_bptr[8]) begin
            wptr <= (wptr == len) ? 4'h0 : 4'(wptr + 4'h1);
          end
        end
      end
    end

    // Error interval counter, counted in output bit pairs
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        ecnt <= 16'h0000;
      end else if (ce) begin
        if (restart[c] || !cfg[c].err_en) begin
          ecnt <= 16'h0000;
        end else if (step) begin
          ecnt <= hit ? 16'h0000 : 16'(ecnt + 16'h0001);
        end
      end
    end

    // Output word, muxed 2:1 downstream
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        ch_data[c] <= 2'h0;
      end else if (ce) begin
        if (!out_en[c]) begin
          ch_data[c] <= 2'h0;
        end else if (step) begin
          ch_data[c] <= pol ^ {hit, 1'b0};
        end
      end
    end
    assign skip_busy[c] = skip;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive indication
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ch_drive <= PSG_OE_RST;
    end else if (ce) begin
      ch_drive <= out_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back, one cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data <= 32'h00000000;
    end else if (ce) begin
      rd_data <= 32'h00000000;
      if (rd_en) begin
        if (addr == PSG_OFS_CTRL) begin
          rd_data[PSG_CTRL_FULL]         <= full_mode;
          rd_data[PSG_CTRL_SEL_LSB +: 3] <= clk_sel;
        end else if (addr == PSG_OFS_OUT_EN) begin
          rd_data[3:0] <= out_en;
        end else if (addr == PSG_OFS_ERR_IVL) begin
          rd_data[15:0] <= err_ivl;
        end else if (addr == PSG_OFS_MEM_ADDR) begin
          rd_data[11:0] <= mem_addr;
        end else if (addr == PSG_OFS_PAIR_LEN) begin
          rd_data[7:0] <= {len_b, len_a};
        end else if (addr == PSG_OFS_STATUS) begin
          rd_data[3:0]                <= skip_busy;
          rd_data[PSG_ST_HOLD]        <= hold;
          rd_data[PSG_ST_OE_LSB +: 4] <= ch_drive;
        end else if (addr[7:4] == PSG_PAGE_CH_CFG) begin
          rd_data[PSG_CFG_PAT_LSB +: 4] <= cfg[sel_ch].pattern;
          rd_data[PSG_CFG_INV]          <= cfg[sel_ch].invert;
          rd_data[PSG_CFG_HALVE]        <= cfg[sel_ch].halve;
          rd_data[PSG_CFG_ERR]          <= cfg[sel_ch].err_en;
          rd_data[PSG_CFG_GRP_LSB +: 2] <= cfg[sel_ch].group;
        end else if (addr[7:4] == PSG_PAGE_CH_DLY) begin
          rd_data[30:0] <= delay[sel_ch];
        end
      end
    end
  end

endmodule : psg_top

// file: verif/psg_sink.sv
`timescale 1ns/1ps
module psg_sink
  import psg_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            capture,
  input wire logic [3:0][1:0] ch_data,
  input wire logic [3:0]      ch_drive
);
  logic bits[PSG_CH][$];

  // Far device takes each lane pair, first-in-time bit first
  always @(posedge sys_clk) begin
    if (capture) begin
      for (int c = 0; c < PSG_CH; c++) begin
        if (ch_drive[c] === 1'b1) begin
          bits[c].push_back(ch_data[c][1]);
          bits[c].push_back(ch_data[c][0]);
        end
      end
    end
  end
endmodule : psg_sink

// file: verif/psg_chk.sv
`timescale 1ns/1ps
module psg_chk
  import psg_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            resetn,
  input wire logic            ce,
  input wire logic [7:0]      addr,
  input wire logic [31:0]     wr_data,
  input wire logic            wr_en,
  input wire logic            rd_en,
  input wire logic [31:0]     rd_data,
  input wire logic [3:0][1:0] ch_data,
  input wire logic [3:0]      ch_drive,
  input wire logic            clk_half_out,
  input wire logic            clk_sel_out
);
  logic [3:0] oe;
  logic [7:0] oe2;
  logic       full;
  logic [2:0] sel;
  logic [3:0] hv;
  logic [3:0] er;

  // Shadow of settings written over the bus
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      oe   <= '0;
      full <= 1'b0;
      sel  <= '0;
      hv   <= '0;
      er   <= '0;
    end else if (ce && wr_en) begin
      if (addr == PSG_OFS_OUT_EN) begin
        oe <= wr_data[3:0];
      end
      if (addr == PSG_OFS_CTRL) begin
        full <= wr_data[PSG_CTRL_FULL];
        sel  <= wr_data[PSG_CTRL_SEL_LSB +: 3];
      end
      if (addr[7:4] == PSG_PAGE_CH_CFG) begin
        hv[addr[3:2]] <= wr_data[PSG_CFG_HALVE];
        er[addr[3:2]] <= wr_data[PSG_CFG_ERR];
      end
    end
  end

  // Enable spread over both lanes of each channel
  assign oe2 = {{2{oe[3]}}, {2{oe[2]}}, {2{oe[1]}}, {2{oe[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence step_seen;
    ce && full && $past(full, 2) && oe == $past(oe, 2) && $changed(ch_data);
  endsequence
  sequence sel_live;
    sel == 3'h0 && $past(sel) == 3'h0 && $past(sel, 2) == 3'h0 && $past(ce) && $past(ce, 2)
      && $past(resetn) && $past(resetn, 2) && $past(resetn, 3);
  endsequence

  drive_follow_a: assert property ($past(ce) |-> ch_drive == $past(oe))
    else $error("channel drive does not follow enable");
  data_off_a: assert property ($past(ce) |-> (ch_data & ~$past(oe2)) == 8'h00)
    else $error("disabled channel shows data");
  reset_quiet_a: assert property (!$past(resetn) |-> ch_drive == 4'h0 && ch_data == 8'h00)
    else $error("outputs live right after reset");
  half_toggle_a: assert property ($past(ce) && $past(resetn) |-> clk_half_out != $past(clk_half_out))
    else $error("half clock output missed a toggle");
  sel_toggle_a: assert property (sel_live |-> clk_sel_out != $past(clk_sel_out))
    else $error("divide by two select output missed a toggle");
  ce_freeze_a: assert property ($past(resetn) && !$past(ce) |-> $stable(ch_data) && $stable(clk_sel_out))
    else $error("outputs moved without clock enable");
  halve_pair_a: assert property (hv[2] && $past(hv[2]) && !er[2] && !$past(er[2])
    |-> ch_data[2][1] == ch_data[2][0])
    else $error("halved channel sent unequal bits");
  full_step_a: assert property (step_seen |=> $stable(ch_data))
    else $error("full clock mode stepped twice in a row");
endmodule : psg_chk

// file: verif/multichannel_prbs_pattern_gen_tb_top.sv
`timescale 1ns/1ps
module multichannel_prbs_pattern_gen_tb_top
  import psg_pkg::*;
;
  logic            sys_clk;
  logic            resetn;
  logic            ce;
  logic [7:0]      addr;
  logic [31:0]     wr_data;
  logic            wr_en;
  logic            rd_en;
  logic [31:0]     rd_data;
  logic [3:0][1:0] ch_data;
  logic [3:0]      ch_drive;
  logic            clk_half_out;
  logic            clk_sel_out;
  logic            capture;
  logic            rd_seen = 1'b0;
  logic [31:0]     exp_q[$];
  logic [255:0]    upat;
  int              fail_count = 0;
  int              n_compared = 0;
  int              cyc = 0;
  int              klist[9] = '{7, 9, 10, 11, 13, 15, 20, 23, 31};

  psg_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ch_data(ch_data), .ch_drive(ch_drive),
    .clk_half_out(clk_half_out), .clk_sel_out(clk_sel_out));
  psg_sink i_sink (.sys_clk(sys_clk), .capture(capture), .ch_data(ch_data), .ch_drive(ch_drive));

  // Clock at 50 ns
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic run_cap(input int n);
    for (int c = 0; c < 4; c++) i_sink.bits[c].delete();
    capture <= 1'b1;
    repeat (n) @(posedge sys_clk);
    capture <= 1'b0;
    @(posedge sys_clk);
  endtask : run_cap

  // Read data against the oldest noted expectation, plus hang limit
  always @(posedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) chk32(rd_data, exp_q.pop_front());
    rd_seen <= rd_en && ce && resetn;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      $display("ERROR %0t run did not finish", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int bad;
    int bad1;
    int bad2;
    int ones;
    int found;
    int n1;
    int n2;
    int m;
    int r;
    int L;
    int n;
    logic last;
    resetn = 1'b0;
    ce = 1'b1;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    capture = 1'b0;
    n2 = $urandom(10);
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(PSG_OFS_OUT_EN, 32'h0);
    rd(PSG_OFS_ERR_IVL, {16'h0, PSG_ERR_IVL_RST});
    rd(PSG_OFS_RESTART, 32'h0);
    rd(8'hfc, 32'h0);
    chk32({28'h0, ch_drive}, 32'h0);
    // One 256-bit user word on channel 3, equal pair lengths
    for (int s = 0; s < 8; s++) begin
      upat[s*32 +: 32] = $urandom();
      wr(PSG_OFS_MEM_ADDR, 32'(s << PSG_MA_SLICE_LSB) | 32'h3);
      wr(PSG_OFS_MEM_DATA, upat[s*32 +: 32]);
    end
    wr(PSG_OFS_PAIR_LEN, 32'h0);
    wr(8'h2c, {28'h0, PSG_PAT_USER});
    // Every sequence length: plain, inverted and halved channels
    for (int p = 0; p < 9; p++) begin
      L = (1 << klist[p]) - 1;
      n = (p < 5) ? 2 * L + 2 : 64;
      wr(8'h20, 32'(p));
      wr(8'h24, 32'(p) | 32'h10);
      wr(8'h28, 32'(p) | 32'h20);
      wr(PSG_OFS_RESTART, 32'h1);
      wr(PSG_OFS_OUT_EN, 32'hf);
      run_cap(n);
      bad = 0;
      bad1 = 0;
      bad2 = 0;
      ones = 0;
      for (int i = 0; i < 2 * n; i++) begin
        if (i_sink.bits[1][i] !== ~i_sink.bits[0][i]) bad1++;
        if (i % 2 == 0 && i_sink.bits[2][i] !== i_sink.bits[2][i+1]) bad2++;
        if (p < 5 && i < L) begin
          ones += int'(i_sink.bits[0][i] === 1'b1);
          if (i_sink.bits[0][i] !== i_sink.bits[0][i+L]) bad++;
          if (i_sink.bits[2][2*i] !== i_sink.bits[2][2*i+2*L]) bad++;
        end
      end
      chkn(bad1, 0);
      chkn(bad2, 0);
      chkn(i_sink.bits[0].size(), 2 * n);
      if (p < 5) begin
        chkn(bad, 0);
        chkn(ones, 1 << (klist[p] - 1));
      end
      if (p == 0) begin
        found = 0;
        for (int s = 0; s < 256; s++) begin
          m = 0;
          for (int i = 0; i < 512; i++) if (i_sink.bits[3][i] !== upat[(i + s) % 256]) m++;
          if (m == 0) found++;
        end
        chkn(found, 1);
      end
    end
    // Error injection on channel 1 against clean channel 0
    n = $urandom_range(65535);
    wr(PSG_OFS_ERR_IVL, 32'(n));
    rd(PSG_OFS_ERR_IVL, 32'(n));
    wr(PSG_OFS_ERR_IVL, 32'h5);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h40);
    wr(PSG_OFS_RESTART, 32'h1);
    run_cap(100);
    bad = 0;
    bad1 = 0;
    for (int i = 0; i < 200; i += 2) begin
      if (i_sink.bits[1][i] !== i_sink.bits[0][i]) bad++;
      if (i_sink.bits[1][i+1] !== i_sink.bits[0][i+1]) bad1++;
    end
    chkn(bad, 20);
    chkn(bad1, 0);
    // Start offset on channel 1: whole block held, then one stream shifted
    L = 2 + $urandom_range(29);
    wr(8'h24, 32'h0);
    wr(8'h34, 32'(L));
    rd(8'h34, 32'(L));
    wr(PSG_OFS_RESTART, 32'h1);
    rd(PSG_OFS_STATUS, (32'hf << PSG_ST_OE_LSB) | (32'h1 << PSG_ST_HOLD) | 32'h2);
    repeat (30) @(posedge sys_clk);
    rd(PSG_OFS_STATUS, 32'hf << PSG_ST_OE_LSB);
    run_cap(64);
    bad = 0;
    for (int i = 0; i < 128 - L; i++) if (i_sink.bits[1][i] !== i_sink.bits[0][i + L]) bad++;
    chkn(bad, 0);
    // Full clock mode, then a frozen stretch
    wr(PSG_OFS_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    ce <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ce <= 1'b1;
    // Divider ratios, the out-of-range code clamps to the largest
    for (int s = 0; s < 8; s++) begin
      wr(PSG_OFS_CTRL, 32'(s << PSG_CTRL_SEL_LSB));
      r = 0;
      m = 0;
      n1 = 0;
      n2 = 0;
      last = clk_sel_out;
      while (r < 3 && m < 800) begin
        @(posedge sys_clk);
        m++;
        if (clk_sel_out === 1'b1 && last === 1'b0) begin
          n1 = n2;
          n2 = m;
          r++;
        end
        last = clk_sel_out;
      end
      chkn(n2 - n1, 1 << ((s > 6 ? 6 : s) + 1));
    end
    // Switch off, then reset in mid-run with outputs on
    wr(PSG_OFS_OUT_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk32({24'h0, ch_data}, 32'h0);
    chk32({28'h0, ch_drive}, 32'h0);
    wr(PSG_OFS_OUT_EN, 32'hf);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(PSG_OFS_OUT_EN, 32'h0);
    @(posedge sys_clk);
    summarize();
  end
endmodule : multichannel_prbs_pattern_gen_tb_top

bind psg_top psg_chk i_chk (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ch_data(ch_data),
  .ch_drive(ch_drive), .clk_half_out(clk_half_out), .clk_sel_out(clk_sel_out));
